// [src/pll_synth_pkg.sv]
// Behaviour
// [R1] reference divided by 8,64,128,256,512,1024,1160,2048 per 3-bit select
// [R2] main and swallow counters step on rising prescaled vco input edges
// [R3] main counter is a 10-bit down-counter, divide values 3 to 1023
// [R4] main counter reloads from main presets each time it reaches zero
// [R5] main preset bit 0 is lsb, bit 9 is msb
// [R6] swallow counter is a 6-bit down-counter, values 0 to 63
// [R7] modulus control low from cycle start until swallow count runs out
// [R8] modulus control high for the remaining N minus A edges
// [R9] at main count end, modulus control low, both counters reload, repeat
// [R10] prescaler divides by P when control high, P+1 when low
// [R11] vco fast or leading pulses vco-side error low, reference side high
// [R12] vco slow or lagging pulses reference-side error low, vco side high
// [R13] in lock both error outputs pulse low together for a minimum width
// [R14] lock indicator high when matched, pulses low when out of lock
// [R15] unconnected programming inputs read as logic 1
// [R16] divided vco signal feeds the phase detector directly
// [R17] one divided reference event per ratio cycles, compared to divided vco
// [R18] programming inputs sampled at reload, effective from next cycle
package pll_synth_pkg;
  localparam int          CLK_MHZ       = 200;
  localparam int          PD_MIN_NS     = 10;                         // error pulse minimum width
  localparam int          PD_MIN_CYC    = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          N_W           = 10;
  localparam int          A_W           = 6;
  localparam int          R_W           = 12;
  localparam int          SEL_W         = 3;
  localparam int          SYNC_W        = N_W + A_W + SEL_W + 2;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  PRESET_OFS    = 8'h04;
  localparam logic [7:0]  STATUS_OFS    = 8'h08;
  localparam logic [7:0]  MASK_OFS      = 8'h0c;
  localparam logic [7:0]  STATE_OFS     = 8'h10;
  // field positions and reset values
  localparam int          ST_UNLOCK     = 0;
  localparam int          ST_VLEAD      = 1;
  localparam int          ST_RLEAD      = 2;
  localparam int          EV_W          = 3;
  localparam logic [18:0] PRESET_RST    = 19'h7ffff;
  localparam logic [EV_W-1:0] MASK_RST  = 3'h0;

  typedef struct packed {
    logic [SEL_W-1:0] rsel;
    logic [A_W-1:0]   a;
    logic [N_W-1:0]   n;
  } prog_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR   = 2'b01,
    BUS_RD   = 2'b10,
    BUS_RDY  = 2'b11
  } bus_state_type;

  // reference ratio table
  function automatic logic [R_W-1:0] ref_ratio(input logic [SEL_W-1:0] s);
    unique case (s)
      3'h0: ref_ratio = 12'h008;
      3'h1: ref_ratio = 12'h040;
      3'h2: ref_ratio = 12'h080;
      3'h3: ref_ratio = 12'h100;
      3'h4: ref_ratio = 12'h200;
      3'h5: ref_ratio = 12'h400;
      3'h6: ref_ratio = 12'h488;
      3'h7: ref_ratio = 12'h800;
    endcase
  endfunction
endpackage

// [src/pll_synth_core.sv]
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_core
  import pll_synth_pkg::*;
(
  input  wire logic             CLK_IN,        // 200 MHz system clock
  input  wire logic             RESET_N_IN,    // async reset, active low
  input  wire logic             REF_OSC_IN,    // reference oscillator pin
  input  wire logic             FIN_IN,        // prescaled vco input pin
  input  wire logic [SEL_W-1:0] REF_SEL_IN,    // reference select pins
  input  wire logic [N_W-1:0]   MAIN_PRESET_IN,    // main preset pins
  input  wire logic [A_W-1:0]   SWALLOW_PRESET_IN, // swallow preset pins
  output logic                  MOD_CTRL_OUT,  // modulus control to prescaler
  output logic                  PHI_V_N_OUT,   // vco-side error, low pulses
  output logic                  PHI_R_N_OUT,   // reference-side error, low pulses
  output logic                  LOCK_OUT,      // lock indicator
  output logic                  DIV_VCO_OUT,   // divided vco pulse
  output logic                  DIV_REF_OUT,   // divided reference pulse
  output logic                  IRQ_OUT,       // interrupt, active high level
  input  wire logic             HSEL_IN,       // ahb select
  input  wire logic [7:0]       HADDR_IN,      // ahb address
  input  wire logic [1:0]       HTRANS_IN,     // ahb transfer type
  input  wire logic             HWRITE_IN,     // ahb write
  input  wire logic [2:0]       HSIZE_IN,      // ahb size, word only
  input  wire logic [31:0]      HWDATA_IN,     // ahb write data
  input  wire logic             HREADY_IN,     // ahb bus ready
  output logic                  HREADYOUT_OUT, // ahb slave ready
  output logic                  HRESP_OUT,     // ahb response, always okay
  output logic [31:0]           HRDATA_OUT     // ahb read data
);
  logic              rst_s1_r, rst_n;
  logic [SYNC_W-1:0] sync1_r, sync2_r, sync3_r;
  logic              ref_edge, fin_edge;
  prog_type          pins;
  // reset release through two flops
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end
  // pin synchronisers, third stage for edge detect
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
    end else begin
      sync1_r <= {REF_OSC_IN, FIN_IN, REF_SEL_IN, SWALLOW_PRESET_IN, MAIN_PRESET_IN};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  // [R2] rising edge detect
  assign ref_edge = sync2_r[SYNC_W-1] & ~sync3_r[SYNC_W-1];
  assign fin_edge = sync2_r[SYNC_W-2] & ~sync3_r[SYNC_W-2];
  // [R5] preset bit order kept lsb first
  assign pins = prog_type'(sync2_r[SYNC_W-3:0]);

  // registers
  logic            use_sw_r, use_sw_nxt;
  logic [18:0]     preset_r, preset_nxt;
  logic [EV_W-1:0] status_r, status_nxt, mask_r, mask_nxt, ev;
  logic [31:0]     rdata_r, rdata_nxt, rd_val;
  logic [7:0]      addr_r, addr_nxt;
  bus_state_type   bus_r, bus_nxt;
  prog_type        prog;
  // programming source: pins or software preset
  assign prog = use_sw_r ? prog_type'(preset_r) : pins;

  // synthesizer state
  logic [R_W-1:0] r_cnt_r, r_cnt_nxt;
  logic [SEL_W-1:0] rsel_r, rsel_nxt;
  logic [N_W-1:0] n_cnt_r, n_cnt_nxt;
  logic [A_W-1:0] a_cnt_r, a_cnt_nxt;
  logic           mc_r, mc_nxt, fv_r, fv_nxt, fr_r, fr_nxt;
  logic           vp_r, vp_nxt, rp_r, rp_nxt, lock_r, lock_nxt;
  logic [1:0]     pd_cnt_r, pd_cnt_nxt;
  logic           both;
  assign both = vp_r & rp_r;
  always_comb begin
    r_cnt_nxt  = r_cnt_r;
    rsel_nxt   = rsel_r;
    fr_nxt     = 1'b0;
    n_cnt_nxt  = n_cnt_r;
    a_cnt_nxt  = a_cnt_r;
    mc_nxt     = mc_r;
    fv_nxt     = 1'b0;
    // [R1] [R17] reference divider, ratio latched at wrap
    if (ref_edge) begin
      if (r_cnt_r >= ref_ratio(rsel_r) - 12'h001) begin
        r_cnt_nxt = '0;
        rsel_nxt  = prog.rsel;
        fr_nxt    = 1'b1;
      end else begin
        r_cnt_nxt = r_cnt_r + 12'h001;
      end
    end
    if (fin_edge) begin
      if (n_cnt_r <= 10'h001) begin
        // [R4] [R9] [R18] reload both counters from sampled presets
        n_cnt_nxt = (prog.n < 10'h003) ? 10'h003 : prog.n;
        a_cnt_nxt = prog.a;
        // [R7] control low at start unless no swallow
        mc_nxt    = (prog.a == '0);
        fv_nxt    = 1'b1;
      end else begin
        // [R3] main down-count
        n_cnt_nxt = n_cnt_r - 10'h001;
        // [R6] [R8] swallow down-count, control high when done
        if (a_cnt_r != '0) begin
          a_cnt_nxt = a_cnt_r - 6'h01;
          if (a_cnt_r == 6'h01)
            mc_nxt = 1'b1;
        end
      end
    end
    // [R11] [R12] [R16] edge-set error flags, set beats clear
    vp_nxt     = vp_r;
    rp_nxt     = rp_r;
    pd_cnt_nxt = '0;
    if (both) begin
      pd_cnt_nxt = pd_cnt_r + 2'h1;
      // [R13] joint low pulse held for minimum width
      if (pd_cnt_r == 2'(PD_MIN_CYC - 1)) begin
        vp_nxt     = 1'b0;
        rp_nxt     = 1'b0;
        pd_cnt_nxt = '0;
      end
    end
    if (fv_r)
      vp_nxt = 1'b1;
    if (fr_r)
      rp_nxt = 1'b1;
    // [R14] lock drops while only one side pending
    lock_nxt = ~(vp_r ^ rp_r);
  end
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      r_cnt_r  <= '0;
      rsel_r   <= '1;
      n_cnt_r  <= '0;
      a_cnt_r  <= '0;
      mc_r     <= 1'b0;
      fv_r     <= 1'b0;
      fr_r     <= 1'b0;
      vp_r     <= 1'b0;
      rp_r     <= 1'b0;
      pd_cnt_r <= '0;
      lock_r   <= 1'b1;
    end else begin
      r_cnt_r  <= r_cnt_nxt;
      rsel_r   <= rsel_nxt;
      n_cnt_r  <= n_cnt_nxt;
      a_cnt_r  <= a_cnt_nxt;
      mc_r     <= mc_nxt;
      fv_r     <= fv_nxt;
      fr_r     <= fr_nxt;
      vp_r     <= vp_nxt;
      rp_r     <= rp_nxt;
      pd_cnt_r <= pd_cnt_nxt;
      lock_r   <= lock_nxt;
    end
  end
  // pin outputs
  assign MOD_CTRL_OUT = mc_r;
  assign PHI_V_N_OUT  = ~vp_r;
  assign PHI_R_N_OUT  = ~rp_r;
  assign LOCK_OUT     = lock_r;
  assign DIV_VCO_OUT  = fv_r;
  assign DIV_REF_OUT  = fr_r;

  // events and interrupt
  assign ev      = {rp_r & ~vp_r, vp_r & ~rp_r, ~lock_r};
  assign IRQ_OUT = |(status_r & mask_r);

  // read mux
  always_comb begin
    unique case (addr_r)
      CTRL_OFS:   rd_val = {31'h0, use_sw_r};
      PRESET_OFS: rd_val = {13'h0, preset_r};
      STATUS_OFS: rd_val = {29'h0, status_r};
      MASK_OFS:   rd_val = {29'h0, mask_r};
      STATE_OFS:  rd_val = {12'h0, a_cnt_r, n_cnt_r, lock_r, rp_r, vp_r, mc_r};
      default:    rd_val = 32'h0;
    endcase
  end
  // ahb slave: writes zero wait, reads one wait
  always_comb begin
    bus_nxt    = bus_r;
    addr_nxt   = addr_r;
    rdata_nxt  = rdata_r;
    use_sw_nxt = use_sw_r;
    preset_nxt = preset_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    if (bus_r == BUS_WR) begin
      unique case (addr_r)
        CTRL_OFS:   use_sw_nxt = HWDATA_IN[0];
        PRESET_OFS: preset_nxt = HWDATA_IN[18:0];
        STATUS_OFS: status_nxt = status_r & ~HWDATA_IN[EV_W-1:0];
        MASK_OFS:   mask_nxt   = HWDATA_IN[EV_W-1:0];
        default:    ;
      endcase
    end
    if (bus_r == BUS_RD) begin
      rdata_nxt = rd_val;
      bus_nxt   = BUS_RDY;
    end else if (HREADYOUT_OUT) begin
      bus_nxt = BUS_IDLE;
      if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
        addr_nxt = {HADDR_IN[7:2], 2'b00};
        bus_nxt  = HWRITE_IN ? BUS_WR : BUS_RD;
      end
    end
    // events set sticky bits, set beats the clear
    status_nxt = status_nxt | ev;
  end
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      bus_r    <= BUS_IDLE;
      addr_r   <= '0;
      rdata_r  <= '0;
      use_sw_r <= 1'b0;
      // [R15] software preset defaults to all ones
      preset_r <= PRESET_RST;
      mask_r   <= MASK_RST;
      status_r <= '0;
    end else begin
      bus_r    <= bus_nxt;
      addr_r   <= addr_nxt;
      rdata_r  <= rdata_nxt;
      use_sw_r <= use_sw_nxt;
      preset_r <= preset_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
    end
  end
  assign HREADYOUT_OUT = (bus_r != BUS_RD);
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = rdata_r;

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);
  a_ref_wrap_bound: assert property (r_cnt_r < ref_ratio(rsel_r)) // [R1]
    else $error("reference count beyond ratio");
  a_main_reload_val: assert property (fin_edge && n_cnt_r <= 10'h001 && prog.n >= 10'h003
    |=> n_cnt_r == $past(prog.n) && fv_r) // [R4]
    else $error("main counter reload wrong");
  a_mc_start_low: assert property (fin_edge && n_cnt_r <= 10'h001 && prog.a != '0
    |=> !mc_r) // [R7]
    else $error("modulus control not low at cycle start");
  a_mc_swallow_end: assert property (fin_edge && n_cnt_r > 10'h001 && a_cnt_r == 6'h01
    |=> mc_r && a_cnt_r == '0) // [R8]
    else $error("modulus control not high after swallow");
  a_mc_hold: assert property (!fin_edge |=> $stable(mc_r)) // [R9]
    else $error("modulus control moved without input edge");
  a_pd_joint_width: assert property ($rose(both) |-> both [*2] ##1 !both) // [R13]
    else $error("joint error pulse width wrong");
  a_pd_vco_lead: assert property (fv_r && !rp_r && !vp_r |=> !PHI_V_N_OUT && PHI_R_N_OUT) // [R11]
    else $error("vco lead not flagged on vco side");
  a_pd_ref_lead: assert property (fr_r && !rp_r && !vp_r |=> !PHI_R_N_OUT && PHI_V_N_OUT) // [R12]
    else $error("reference lead not flagged on reference side");
  a_lock_drop: assert property (vp_r && !rp_r |=> !LOCK_OUT ##1 status_r[ST_UNLOCK]) // [R14]
    else $error("lock not dropped or not recorded");
  a_read_wait: assert property (bus_r == BUS_RD |-> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read wait state wrong");
  // counter stepping, reload sampling and detector feed
  a_fin_step_only: assert property (!fin_edge |=> $stable(n_cnt_r) && $stable(a_cnt_r)) // [R2]
    else $error("counters moved without input edge");
  a_main_step_down: assert property (fin_edge && n_cnt_r > 10'h001
    |=> n_cnt_r == $past(n_cnt_r) - 10'h001) // [R3]
    else $error("main counter step wrong");
  a_swallow_step: assert property (fin_edge && n_cnt_r > 10'h001 && a_cnt_r != '0
    |=> a_cnt_r == $past(a_cnt_r) - 6'h01) // [R6]
    else $error("swallow counter step wrong");
  a_swallow_load: assert property (fin_edge && n_cnt_r <= 10'h001
    |=> a_cnt_r == $past(prog.a)) // [R18]
    else $error("swallow counter reload wrong");
  a_mc_no_swallow: assert property (fin_edge && n_cnt_r <= 10'h001 && prog.a == '0
    |=> mc_r) // [R8]
    else $error("modulus control low with zero swallow");
  a_ref_pulse_wrap: assert property (ref_edge && r_cnt_r >= ref_ratio(rsel_r) - 12'h001
    |=> fr_r && r_cnt_r == '0) // [R17]
    else $error("reference wrap without pulse");
  a_vco_to_pd: assert property (fv_r |=> vp_r) // [R16]
    else $error("divided vco pulse not seen by detector");
  a_ref_to_pd: assert property (fr_r |=> rp_r) // [R17]
    else $error("divided reference pulse not seen by detector");
  a_lock_high: assert property (!vp_r && !rp_r |=> LOCK_OUT) // [R14]
    else $error("lock low with no pending error");
  c_ref_wrap: cover property (fr_r);
  c_locked_cycle: cover property ($rose(both) ##[1:8] !both);
  c_swallow_done: cover property ($rose(mc_r));
  c_irq_raise: cover property ($rose(IRQ_OUT));
  c_reg_read: cover property (bus_r == BUS_RD ##1 bus_r == BUS_RDY);
endmodule // pll_synth_core
`default_nettype wire

// [testbench/prescaler_model.sv]
`timescale 1ns/1ps
`default_nettype none
module prescaler_model #(
  parameter int P = 8              // divide with control high
) (
  input  wire logic clk_in,        // system clock
  input  wire logic rst_n_in,      // reset, active low
  input  wire logic run_in,        // vco running
  input  wire logic mod_ctrl_in,   // modulus control
  output logic      fin_out        // prescaled vco
);
  logic [4:0] cnt_r;
  logic [4:0] last_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 5'h00;
      last_r <= 5'(P);
    end else if (run_in) begin
      cnt_r <= (cnt_r == last_r) ? 5'h00 : cnt_r + 5'h01;
      // length picked once control has settled
      if (cnt_r == 5'h06) last_r <= mod_ctrl_in ? 5'(P - 1) : 5'(P);
    end
  end
  // high four clocks per period
  assign fin_out = (cnt_r < 5'h04);
endmodule // prescaler_model
`default_nettype wire

// [testbench/pll_synth_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_synth_core_tb_top;
  import pll_synth_pkg::*;
  localparam int P = 8;
  localparam int LIM = 20000;
  logic        CLK_IN, RESET_N_IN, HSEL_IN, HWRITE_IN, fin_run, ref_run;
  logic        MOD_CTRL_OUT, PHI_V_N_OUT, PHI_R_N_OUT, LOCK_OUT, DIV_VCO_OUT, DIV_REF_OUT;
  logic        IRQ_OUT, HREADYOUT_OUT, HRESP_OUT;
  wire logic   FIN_IN, REF_OSC_IN;
  logic [2:0]  REF_SEL_IN, HSIZE_IN;
  logic [9:0]  MAIN_PRESET_IN;
  logic [5:0]  SWALLOW_PRESET_IN;
  logic [7:0]  HADDR_IN;
  logic [1:0]  HTRANS_IN, ref_ph;
  logic [31:0] HWDATA_IN, HRDATA_OUT, rd;
  int          fails, tests_run, cv, cr, lowc;
  int          qv[$], qr[$], ql[$];
  int          ratio_t[8] = '{8, 64, 128, 256, 512, 1024, 1160, 2048};

  pll_synth_core dut_u (.CLK_IN, .RESET_N_IN, .REF_OSC_IN, .FIN_IN, .REF_SEL_IN,
    .MAIN_PRESET_IN, .SWALLOW_PRESET_IN, .MOD_CTRL_OUT, .PHI_V_N_OUT, .PHI_R_N_OUT,
    .LOCK_OUT, .DIV_VCO_OUT, .DIV_REF_OUT, .IRQ_OUT, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
    .HWRITE_IN, .HSIZE_IN, .HWDATA_IN, .HREADY_IN(HREADYOUT_OUT), .HREADYOUT_OUT,
    .HRESP_OUT, .HRDATA_OUT);
  prescaler_model #(.P(P)) psc_u (.clk_in(CLK_IN), .rst_n_in(RESET_N_IN), .run_in(fin_run),
    .mod_ctrl_in(MOD_CTRL_OUT), .fin_out(FIN_IN));

  // clock and reference oscillator, four clocks per period
  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  always @(posedge CLK_IN) if (ref_run) ref_ph <= ref_ph + 2'h1;
  assign REF_OSC_IN = ref_ph[1];

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // bounded wait for a level sampled at rising edges
  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge CLK_IN);
      k++;
    end while (s !== v && k < LIM);
    if (k >= LIM) begin
      fails++;
      report_and_stop();
    end
  endtask

  // one single word transfer, read data left in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK_IN);
    HSEL_IN <= 1'b1;
    HTRANS_IN <= 2'h2;
    HADDR_IN <= a;
    HWRITE_IN <= wr;
    wait_lvl(HREADYOUT_OUT, 1'b1);
    HSEL_IN <= 1'b0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= wd;
    wait_lvl(HREADYOUT_OUT, 1'b1);
    rd = HRDATA_OUT;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0);
    check(w, rd, e);
    check("hresp", HRESP_OUT, 32'h0);
  endtask

  // new presets after one pulse, expectation noted for the following cycle
  task automatic vco_case(input logic [9:0] n, input logic [5:0] a, input int ep, input int el);
    wait_lvl(DIV_VCO_OUT, 1'b1);
    MAIN_PRESET_IN <= n;
    SWALLOW_PRESET_IN <= a;
    wait_lvl(DIV_VCO_OUT, 1'b1);
    qv.push_back(ep);
    ql.push_back(el);
  endtask

  task automatic ref_case(input logic [2:0] s);
    wait_lvl(DIV_REF_OUT, 1'b1);
    REF_SEL_IN <= s;
    wait_lvl(DIV_REF_OUT, 1'b1);
    qr.push_back(ratio_t[s] * 4);
  endtask

  // watcher: pulse spacing and modulus-low time against noted expectations
  always @(negedge CLK_IN) begin
    cv++;
    cr++;
    if (MOD_CTRL_OUT === 1'b0) lowc++;
    if (DIV_VCO_OUT === 1'b1) begin
      if (qv.size() > 0) check("vco period", cv, qv.pop_front());
      if (ql.size() > 0) check("mc low", lowc, ql.pop_front());
      cv = 0;
      lowc = 0;
    end
    if (DIV_REF_OUT === 1'b1) begin
      if (qr.size() > 0) check("ref period", cr, qr.pop_front());
      cr = 0;
    end
  end

  initial begin
    logic [9:0] n;
    logic [5:0] a;
    fails = 0;
    tests_run = 0;
    cv = 0;
    cr = 0;
    lowc = 0;
    ref_ph = 2'h0;
    RESET_N_IN = 1'b0;
    fin_run = 1'b0;
    ref_run = 1'b0;
    HSEL_IN = 1'b0;
    HWRITE_IN = 1'b0;
    HTRANS_IN = 2'h0;
    HADDR_IN = 8'h00;
    HSIZE_IN = 3'h2;
    HWDATA_IN = 32'h0;
    REF_SEL_IN = 3'h7;
    MAIN_PRESET_IN = 10'h3ff;
    SWALLOW_PRESET_IN = 6'h3f;
    void'($urandom(7948));
    repeat (12) @(posedge CLK_IN);
    RESET_N_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    rd_chk(8'h04, 32'h0007ffff, "preset reset");
    rd_chk(8'h0c, 32'h0, "mask reset");
    rd_chk(8'h08, 32'h0, "status reset");
    rd_chk(8'h20, 32'h0, "unmapped");
    // vco pulse alone: vco side leads
    MAIN_PRESET_IN <= 10'h010;
    SWALLOW_PRESET_IN <= 6'h00;
    fin_run <= 1'b1;
    wait_lvl(DIV_VCO_OUT, 1'b1);
    fin_run <= 1'b0;
    repeat (3) @(posedge CLK_IN);
    check("lead phi_v", PHI_V_N_OUT, 32'h0);
    check("lead phi_r", PHI_R_N_OUT, 32'h1);
    check("lead lock", LOCK_OUT, 32'h0);
    rd_chk(8'h08, 32'h3, "status lead");
    bus(1'b1, 8'h0c, 32'h7);
    @(posedge CLK_IN);
    check("irq on", IRQ_OUT, 32'h1);
    bus(1'b1, 8'h0c, 32'h4);
    @(posedge CLK_IN);
    check("irq masked", IRQ_OUT, 32'h0);
    // reference catches up: both pulse together
    ref_run <= 1'b1;
    wait_lvl(PHI_R_N_OUT, 1'b0);
    ref_run <= 1'b0;
    check("both low", PHI_V_N_OUT, 32'h0);
    repeat (2) @(posedge CLK_IN);
    check("both high", {PHI_V_N_OUT, PHI_R_N_OUT}, 32'h3);
    check("relock", LOCK_OUT, 32'h1);
    bus(1'b1, 8'h08, 32'h7);
    rd_chk(8'h08, 32'h0, "status clear");
    bus(1'b1, 8'h0c, 32'h7);
    @(posedge CLK_IN);
    check("irq clear", IRQ_OUT, 32'h0);
    // every reference ratio, vco held still
    ref_run <= 1'b1;
    for (int s = 0; s < 8; s++) ref_case(3'(s));
    wait_lvl(DIV_REF_OUT, 1'b1);
    check("lag phi_r", PHI_R_N_OUT, 32'h0);
    check("lag phi_v", PHI_V_N_OUT, 32'h1);
    ref_run <= 1'b0;
    // divide ratios at the range ends, random, then software presets
    fin_run <= 1'b1;
    vco_case(10'h003, 6'h01, 3 * P + 1, P + 1);
    vco_case(10'h001, 6'h00, 3 * P, 0);
    vco_case(10'h040, 6'h3f, 64 * P + 63, 63 * (P + 1));
    vco_case(10'h3ff, 6'h3f, 1023 * P + 63, 63 * (P + 1));
    repeat (2) begin
      n = 10'(64 + $urandom_range(0, 400));
      a = 6'($urandom_range(0, 63));
      vco_case(n, a, n * P + a, a * (P + 1));
    end
    bus(1'b1, 8'h04, 32'h00071414);
    bus(1'b1, 8'h00, 32'h1);
    vco_case(10'h0c8, 6'h09, 20 * P + 5, 5 * (P + 1));
    bus(1'b1, 8'h00, 32'h0);
    wait_lvl(DIV_VCO_OUT, 1'b1);
    report_and_stop();
  end
endmodule // pll_synth_core_tb_top
`default_nettype wire
